// >>> verif/spi_cfg_monitor.sv
`timescale 1ns/1ns
module spi_cfg_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link wires
  input wire logic csN,
  input wire logic csPin,
  input wire logic sclk,
  input wire logic ctrlOut,
  input wire logic ctrlOe,
  input wire logic devOut,
  input wire logic devOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_selFall;
    $fell(csN);
  endsequence
  sequence s_quietSetup;
    !sclk [*8];
  endsequence

  property p_frame_start;
    s_selFall |-> s_quietSetup ##[1:12] sclk;
  endproperty
  property p_idle_clock;
    csN |-> !sclk;
  endproperty
  property p_no_fight;
    !(ctrlOe && devOe);
  endproperty
  // Device needs a few cycles to see select through its synchroniser
  property p_dev_quiet;
    csPin [*8] |-> !devOe;
  endproperty
  property p_dev_release;
    $rose(csPin) |-> ##[0:6] !devOe;
  endproperty
  property p_high_width;
    $rose(sclk) |-> sclk [*7];
  endproperty
  property p_ctrl_hold;
    ctrlOe && sclk && $past(sclk) |-> $stable(ctrlOut);
  endproperty
  property p_dev_hold;
    devOe && sclk && $past(sclk) |-> $stable(devOut);
  endproperty
  property p_oe_release;
    $rose(csN) |-> !ctrlOe;
  endproperty

  a_frame_start: assert property (p_frame_start)
    else $error("serial clock timing after select fall is wrong");
  a_idle_clock: assert property (p_idle_clock)
    else $error("serial clock moved while deselected");
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data wire");
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives data while deselected");
  a_dev_release: assert property (p_dev_release)
    else $error("device kept data wire after select rose");
  a_high_width: assert property (p_high_width)
    else $error("serial clock high phase too short");
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("controller data changed while clock high");
  a_dev_hold: assert property (p_dev_hold)
    else $error("device data changed while clock high");
  a_oe_release: assert property (p_oe_release)
    else $error("controller still drives at frame end");
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  typedef struct {logic rd; logic [12:0] addr; logic [1:0] wlen; logic stall;
    logic [1:0] scnt; logic [31:0] data; logic [31:0] expVal;} row_t;
  logic clk, reset, psel, penable, pwrite, pready_r, pslverr_r;
  logic [7:0] paddr, cfgAddr, cfgData_r;
  logic [31:0] pwdata, prdata_r;
  logic secondaryStrap, twoWireStrap, transferPulse_r;
  logic secondaryMode_r, twoWireMode_r, altSclk_r, altSdio_r;
  logic [63:0] cap;
  int error_cnt = 0;
  int num_checks = 0;
  int pulseCnt = 0;
  int devOeCnt = 0;
  int altCnt = 0;
  int altDataCnt = 0;
  row_t rows [11] = '{
    '{1'b0, 13'h0010, 2'h0, 1'b0, 2'h0, 32'h0000_00A5, 32'h0},
    '{1'b1, 13'h0010, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0000_00A5},
    '{1'b0, 13'h0020, 2'h1, 1'b1, 2'h0, 32'h0000_1234, 32'h0},
    '{1'b1, 13'h0021, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0000_0012},
    '{1'b1, 13'h0020, 2'h1, 1'b1, 2'h0, 32'h0, 32'h0000_1234},
    '{1'b0, 13'h0030, 2'h2, 1'b1, 2'h0, 32'h0096_3C5A, 32'h0},
    '{1'b1, 13'h0030, 2'h2, 1'b0, 2'h0, 32'h0, 32'h0096_3C5A},
    '{1'b0, 13'h0040, 2'h3, 1'b1, 2'h3, 32'hDEAD_BEEF, 32'h0},
    '{1'b1, 13'h0040, 2'h3, 1'b0, 2'h3, 32'h0, 32'hDEAD_BEEF},
    '{1'b0, 13'h01A5, 2'h0, 1'b0, 2'h0, 32'h0000_0077, 32'h0},
    '{1'b1, 13'h00A5, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0}};

  spi_cfg_if linkIf();
  spi_cfg_ctrl spi_cfg_ctrl_inst(.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .link(linkIf));
  spi_cfg_device spi_cfg_device_inst(.clk(clk), .reset(reset), .link(linkIf),
    .secondaryStrap(secondaryStrap), .twoWireStrap(twoWireStrap), .cfgAddr(cfgAddr),
    .cfgData_r(cfgData_r), .transferPulse_r(transferPulse_r),
    .secondaryMode_r(secondaryMode_r), .twoWireMode_r(twoWireMode_r),
    .altSclk_r(altSclk_r), .altSdio_r(altSdio_r));
  spi_cfg_monitor spi_cfg_monitor_inst(.clk(clk), .reset(reset), .csN(linkIf.csN),
    .csPin(linkIf.csPin), .sclk(linkIf.sclk), .ctrlOut(linkIf.ctrlOut),
    .ctrlOe(linkIf.ctrlOe), .devOut(linkIf.devOut), .devOe(linkIf.devOe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Bit stream as seen on the wire, newest bit at the bottom
  always @(posedge linkIf.sclk) cap <= {cap[62:0], linkIf.sdio};
  always @(posedge clk)
  begin
    if (transferPulse_r === 1'b1) pulseCnt++;
    if (linkIf.devOe === 1'b1) devOeCnt++;
    if (altSclk_r === 1'b1) altCnt++;
    if (altSdio_r === 1'b1) altDataCnt++;
  end

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task hang;
    error_cnt++;
    $display("CHECK FAILED at %0t: got %h expected %h (wait ran out)", $time, 0, 1);
    tally_and_finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready_r !== 1'b1 && n < 20);
    if (pready_r !== 1'b1) hang;
    q = prdata_r;
    err = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic spiOp(input row_t r, input logic lsb, output logic [31:0] q);
    logic [31:0] s;
    logic e;
    int n;
    apb(1'b1, 8'h04, r.data, s, e);
    apb(1'b1, 8'h00, {11'h0, r.scnt, r.stall, lsb, 1'b1, r.rd, r.wlen, r.addr}, s, e);
    n = 0;
    s = 32'h0;
    while (s[1] !== 1'b1 && n < 3000)
    begin
      apb(1'b0, 8'h0C, 32'h0, s, e);
      n++;
    end
    if (s[1] !== 1'b1) hang;
    apb(1'b1, 8'h0C, 32'h0000_0002, s, e);
    apb(1'b0, 8'h08, 32'h0, q, e);
  endtask

  task doReset;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  initial
  begin
    logic [31:0] q;
    logic e;
    int n;
    int p0;
    int d0;
    int a0;
    int s0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {secondaryStrap, twoWireStrap, cfgAddr} = '0;
    linkIf.csTieLow = 1'b0;
    linkIf.csTieHigh = 1'b0;
    doReset;
    apb(1'b0, 8'h0C, 32'h0, q, e);
    `CHK(q, 32'h0)
    apb(1'b0, 8'h10, 32'h0, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    foreach (rows[i])
    begin
      spiOp(rows[i], 1'b0, q);
      if (rows[i].rd) `CHK(q, rows[i].expVal)
    end
    // Buffered byte stays hidden until the transfer bit is written
    cfgAddr <= 8'h50;
    spiOp('{1'b0, 13'h0050, 2'h0, 1'b0, 2'h0, 32'h0000_005A, 32'h0}, 1'b0, q);
    `CHK(cap[23:0], 24'h00_505A)
    `CHK(cfgData_r, 8'h00)
    p0 = pulseCnt;
    spiOp('{1'b0, 13'h00FF, 2'h0, 1'b0, 2'h0, 32'h0000_0001, 32'h0}, 1'b0, q);
    `CHK(cfgData_r, 8'h5A)
    `CHK(pulseCnt, p0 + 1)
    cfgAddr <= 8'h04;
    spiOp('{1'b0, 13'h0004, 2'h0, 1'b0, 2'h0, 32'h0000_005C, 32'h0}, 1'b0, q);
    `CHK(cfgData_r, 8'h5C)
    // Select pulled high in the middle of the data byte
    fork
      spiOp('{1'b0, 13'h0060, 2'h0, 1'b0, 2'h0, 32'h0000_0077, 32'h0}, 1'b0, q);
      begin
        n = 0;
        while (linkIf.csN !== 1'b0 && n < 200)
        begin
          @(posedge clk);
          n++;
        end
        if (linkIf.csN !== 1'b0) hang;
        repeat (310) @(posedge clk);
        linkIf.csTieHigh <= 1'b1;
        repeat (20) @(posedge clk);
        linkIf.csTieHigh <= 1'b0;
      end
    join
    spiOp('{1'b1, 13'h0060, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0}, 1'b0, q);
    `CHK(q, 32'h0)
    // Bit order switch, then back to the power-up order
    spiOp('{1'b0, 13'h0000, 2'h0, 1'b0, 2'h0, 32'h0000_0040, 32'h0}, 1'b0, q);
    spiOp('{1'b0, 13'h0011, 2'h0, 1'b0, 2'h0, 32'h0000_0096, 32'h0}, 1'b1, q);
    `CHK(cap[23:0], 24'h88_0069)
    spiOp('{1'b1, 13'h0011, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0}, 1'b1, q);
    `CHK(q, 32'h0000_0096)
    spiOp('{1'b0, 13'h0000, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0}, 1'b1, q);
    doReset;
    `CHK(cfgData_r, 8'h00)
    secondaryStrap <= 1'b1;
    doReset;
    `CHK(secondaryMode_r, 1'b1)
    d0 = devOeCnt;
    a0 = altCnt;
    s0 = altDataCnt;
    spiOp('{1'b1, 13'h0004, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0}, 1'b0, q);
    `CHK(devOeCnt, d0)
    `CHK(altCnt > a0, 1'b1)
    `CHK(altDataCnt > s0, 1'b1)
    secondaryStrap <= 1'b0;
    twoWireStrap <= 1'b1;
    linkIf.csTieLow <= 1'b1;
    doReset;
    `CHK(twoWireMode_r, 1'b1)
    spiOp('{1'b0, 13'h0012, 2'h0, 1'b0, 2'h0, 32'h0000_003C, 32'h0}, 1'b0, q);
    spiOp('{1'b1, 13'h0012, 2'h0, 1'b0, 2'h0, 32'h0, 32'h0}, 1'b0, q);
    `CHK(q, 32'h0000_003C)
    tally_and_finish;
  end
endmodule

// >>> verilog/spi_cfg_consts.svh
`ifndef SPI_CFG_CONSTS_SVH
`define SPI_CFG_CONSTS_SVH

// Instruction word layout
`define SCP_INSTR_BITS 16
`define SCP_ADDR_W 13
`define SCP_RW_BIT 15
`define SCP_WLEN_HI 14
`define SCP_WLEN_LO 13
`define SCP_WLEN_STREAM 2'h3

// Device register space
`define SCP_MEM_DEPTH 256
`define SCP_ADDR_CFG 8'h00
`define SCP_ADDR_UNBUF_A 8'h04
`define SCP_ADDR_UNBUF_B 8'h05
`define SCP_ADDR_XFER 8'hFF
`define SCP_CFG_LSB_BIT 6
`define SCP_XFER_BIT 0
`define SCP_REG_RESET 8'h00
`define SCP_STRAP_SETTLE 2'h3

// Pin sync reset level: {select, clock, data}
`define SCP_PIN_IDLE 3'h4

// Controller APB map
`define SCP_APB_CMD 8'h00
`define SCP_APB_WDATA 8'h04
`define SCP_APB_RDATA 8'h08
`define SCP_APB_STATUS 8'h0C
`define SCP_CMD_START 16
`define SCP_CMD_LSB 17
`define SCP_CMD_STALL 18
`define SCP_CMD_SCOUNT_HI 20
`define SCP_CMD_SCOUNT_LO 19
`define SCP_STAT_BUSY 0
`define SCP_STAT_DONE 1

// Link timing
`define SCP_CLK_PERIOD_NS 10
`define SCP_SCLK_PERIOD_NS 160
`define SCP_SCLK_HALF ((`SCP_SCLK_PERIOD_NS / `SCP_CLK_PERIOD_NS) / 2)
`define SCP_DRIVE_PHASE 5
`define SCP_GAP_CYC 16

`endif

// >>> verilog/spi_cfg_ctrl.sv
`include "spi_cfg_consts.svh"
`timescale 1ns/1ns
module spi_cfg_ctrl
  import spi_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // Serial link
  spi_cfg_if.ctrl link
);
  localparam logic [4:0] HALF = 5'(`SCP_SCLK_HALF);
  localparam logic [4:0] DRIVE = 5'(`SCP_DRIVE_PHASE);
  localparam logic [4:0] GAP = 5'(`SCP_GAP_CYC);

  logic [2:0] sdioLvl;
  logic apbWrite;
  logic startReq;
  logic reading;
  logic [1:0] rxByteIdx;
  logic [7:0] rxNxt;
  logic [31:0] cmd_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic busy_r;
  logic done_r;
  logic setDone;
  ctrlState_t state_r;
  logic [4:0] phase_r;
  logic [5:0] bitNum_r;
  logic [5:0] totalBits_r;
  logic [47:0] frame_r;
  logic [7:0] rx_r;
  logic rd_r;
  logic lsb_r;
  logic stall_r;
  logic [2:0] nBytes;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  spi_pin_sync #(.RESET_VAL(3'h0)) sdioSync
  (
    .clk(clk),
    .reset(reset),
    .pinIn({2'h0, link.sdio}),
    .level(sdioLvl),
    .rise(),
    .fall()
  );

  assign apbWrite = psel && penable && pready_r && pwrite;
  assign startReq = apbWrite && (paddr == `SCP_APB_CMD) && pwdata[`SCP_CMD_START] && !busy_r;
  // Streaming sends a bounded count of bytes from the data word
  assign nBytes = (pwdata[`SCP_WLEN_HI:`SCP_WLEN_LO] == `SCP_WLEN_STREAM) ?
                  {1'b0, pwdata[`SCP_CMD_SCOUNT_HI:`SCP_CMD_SCOUNT_LO]} + 3'h1 :
                  {1'b0, pwdata[`SCP_WLEN_HI:`SCP_WLEN_LO]} + 3'h1;
  assign reading = rd_r && (bitNum_r >= 6'h10);
  assign rxByteIdx = 2'(bitNum_r[5:3] - 3'h2);
  assign rxNxt = lsb_r ? {sdioLvl[0], rx_r[7:1]} : {rx_r[6:0], sdioLvl[0]};
  assign setDone = (state_r == CT_END) && (phase_r == HALF - 5'h01);

  // Zero-wait APB: ready in every access phase
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel && !penable;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      if (psel && !penable)
      begin
        case (paddr)
          `SCP_APB_CMD: prdata_r <= cmd_r;
          `SCP_APB_WDATA: prdata_r <= wdata_r;
          `SCP_APB_RDATA: prdata_r <= rdata_r;
          `SCP_APB_STATUS: prdata_r <= {30'h0000_0000, done_r, busy_r};
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmd_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
    end
    else if (apbWrite)
    begin
      if (paddr == `SCP_APB_CMD)
      begin
        cmd_r <= {15'h0000, 1'b0, pwdata[15:0]} | (pwdata & 32'h001E_0000);
      end
      if (paddr == `SCP_APB_WDATA)
      begin
        wdata_r <= pwdata;
      end
    end
  end

  // Done is sticky; a new completion wins over a write-one clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      busy_r <= startReq | (busy_r & ~setDone);
      done_r <= setDone | (done_r & ~(apbWrite && paddr == `SCP_APB_STATUS &&
                                      pwdata[`SCP_STAT_DONE]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= CT_IDLE;
      link.csN <= 1'b1;
      link.sclk <= 1'b0;
      link.ctrlOut <= 1'b0;
      link.ctrlOe <= 1'b0;
      phase_r <= 5'h00;
      bitNum_r <= 6'h00;
      totalBits_r <= 6'h00;
      frame_r <= 48'h0000_0000_0000;
      rx_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      rd_r <= 1'b0;
      lsb_r <= 1'b0;
      stall_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        CT_IDLE:
        begin
          if (startReq)
          begin
            rd_r <= pwdata[`SCP_RW_BIT];
            lsb_r <= pwdata[`SCP_CMD_LSB];
            // No stalls in streaming: a select rise there ends the frame
            stall_r <= pwdata[`SCP_CMD_STALL] &&
                       (pwdata[`SCP_WLEN_HI:`SCP_WLEN_LO] != `SCP_WLEN_STREAM);
            if (pwdata[`SCP_CMD_LSB])
            begin
              frame_r <= {rev8(pwdata[7:0]), rev8(pwdata[15:8]), rev8(wdata_r[7:0]),
                          rev8(wdata_r[15:8]), rev8(wdata_r[23:16]), rev8(wdata_r[31:24])};
            end
            else
            begin
              frame_r <= {pwdata[15:0], wdata_r[7:0], wdata_r[15:8], wdata_r[23:16],
                          wdata_r[31:24]};
            end
            totalBits_r <= 6'h10 + {nBytes, 3'h0};
            rdata_r <= 32'h0000_0000;
            bitNum_r <= 6'h00;
            phase_r <= 5'h00;
            link.csN <= 1'b0;
            state_r <= CT_SETUP;
          end
        end
        CT_SETUP:
        begin
          phase_r <= phase_r + 5'h01;
          if (phase_r == HALF - 5'h01)
          begin
            phase_r <= 5'h00;
            state_r <= CT_BIT;
          end
        end
        CT_BIT:
        begin
          phase_r <= phase_r + 5'h01;
          if (phase_r == DRIVE)
          begin
            link.ctrlOut <= frame_r[47];
            link.ctrlOe <= !reading;
          end
          if (phase_r == HALF)
          begin
            link.sclk <= 1'b1;
            if (reading)
            begin
              rx_r <= rxNxt;
              if (bitNum_r[2:0] == 3'h7)
              begin
                rdata_r[{rxByteIdx, 3'h0} +: 8] <= rxNxt;
              end
            end
          end
          if (phase_r == HALF + HALF - 5'h01)
          begin
            link.sclk <= 1'b0;
            phase_r <= 5'h00;
            frame_r <= {frame_r[46:0], 1'b0};
            bitNum_r <= bitNum_r + 6'h01;
            // Release the wire at the fall before the device turns it round
            if (rd_r && bitNum_r == 6'h0F)
            begin
              link.ctrlOe <= 1'b0;
            end
            if (bitNum_r == totalBits_r - 6'h01)
            begin
              link.ctrlOe <= 1'b0;
              state_r <= CT_END;
            end
            else if (stall_r && bitNum_r[2:0] == 3'h7)
            begin
              // Let go of the wire while deselected; driven again at the next drive phase unless reading
              link.ctrlOe <= 1'b0;
              link.csN <= 1'b1;
              state_r <= CT_GAP;
            end
          end
        end
        CT_GAP:
        begin
          phase_r <= phase_r + 5'h01;
          if (phase_r == GAP - 5'h01)
          begin
            phase_r <= 5'h00;
            link.csN <= 1'b0;
            state_r <= CT_SETUP;
          end
        end
        CT_END:
        begin
          phase_r <= phase_r + 5'h01;
          if (setDone)
          begin
            phase_r <= 5'h00;
            link.csN <= 1'b1;
            state_r <= CT_IDLE;
          end
        end
        default:
        begin
          state_r <= CT_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> verilog/spi_cfg_device.sv
`include "spi_cfg_consts.svh"
`timescale 1ns/1ns
module spi_cfg_device
  import spi_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link
  spi_cfg_if.dev link,
  // Board straps
  input wire logic secondaryStrap,
  input wire logic twoWireStrap,
  // Applied register readout
  input wire logic [7:0] cfgAddr,
  output logic [7:0] cfgData_r,
  output logic transferPulse_r,
  // Strap state and secondary pin functions
  output logic secondaryMode_r,
  output logic twoWireMode_r,
  output logic altSclk_r,
  output logic altSdio_r
);
  logic [2:0] pinLvl;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  logic [2:0] strapLvl;
  logic [1:0] strapCnt_r;
  logic strapDone_r;
  logic run;
  logic csActive;
  logic sclkRise;
  logic sclkFall;
  logic lsbFirst;
  devState_t state_r;
  logic [3:0] cnt_r;
  logic [15:0] shift_r;
  logic [15:0] shiftNxt;
  logic rw_r;
  logic stream_r;
  logic [1:0] bytesLeft_r;
  logic [12:0] addr_r;
  logic [7:0] tx_r;
  logic instrDone;
  logic byteDone;
  logic wrEn;
  logic [7:0] wrData;
  logic [7:0] shadow_r [`SCP_MEM_DEPTH];
  logic [7:0] live_r [`SCP_MEM_DEPTH];

  function automatic logic [15:0] shiftIn(input logic [15:0] sh, input logic b, input logic lsb);
    return lsb ? {b, sh[15:1]} : {sh[14:0], b};
  endfunction

  function automatic logic [7:0] takeByte(input logic [15:0] sh, input logic lsb);
    return lsb ? sh[15:8] : sh[7:0];
  endfunction

  // Addresses beyond the implemented space read as zero
  function automatic logic [7:0] readByte(input logic [12:0] a);
    return (a[12:8] == 5'h00) ? shadow_r[a[7:0]] : 8'h00;
  endfunction

  spi_pin_sync #(.RESET_VAL(`SCP_PIN_IDLE)) pinSync
  (
    .clk(clk),
    .reset(reset),
    .pinIn({link.csPin, link.sclk, link.sdio}),
    .level(pinLvl),
    .rise(pinRise),
    .fall(pinFall)
  );

  spi_pin_sync #(.RESET_VAL(3'h0)) strapSync
  (
    .clk(clk),
    .reset(reset),
    .pinIn({1'b0, secondaryStrap, twoWireStrap}),
    .level(strapLvl),
    .rise(),
    .fall()
  );

  // Straps are caught once the synchroniser has settled after reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strapCnt_r <= 2'h0;
      strapDone_r <= 1'b0;
      secondaryMode_r <= 1'b0;
      twoWireMode_r <= 1'b0;
    end
    else if (!strapDone_r)
    begin
      strapCnt_r <= strapCnt_r + 2'h1;
      if (strapCnt_r == `SCP_STRAP_SETTLE)
      begin
        strapDone_r <= 1'b1;
        secondaryMode_r <= strapLvl[1];
        twoWireMode_r <= strapLvl[0] & ~strapLvl[1];
      end
    end
  end

  // In secondary mode the pins serve as plain levels for the analog side
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      altSclk_r <= 1'b0;
      altSdio_r <= 1'b0;
    end
    else
    begin
      altSclk_r <= secondaryMode_r & pinLvl[1];
      altSdio_r <= secondaryMode_r & pinLvl[0];
    end
  end

  assign run = strapDone_r & ~secondaryMode_r;
  assign csActive = twoWireMode_r | ~pinLvl[2];
  assign sclkRise = pinRise[1];
  assign sclkFall = pinFall[1];
  assign lsbFirst = live_r[`SCP_ADDR_CFG][`SCP_CFG_LSB_BIT];
  assign shiftNxt = shiftIn(shift_r, pinLvl[0], lsbFirst);
  assign instrDone = (state_r == DEV_INSTR) && (cnt_r == 4'hF);
  assign byteDone = (state_r == DEV_DATA) && (cnt_r[2:0] == 3'h7);
  assign wrData = takeByte(shiftNxt, lsbFirst);
  assign wrEn = run && csActive && sclkRise && byteDone && !rw_r && (addr_r[12:8] == 5'h00);

  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      state_r <= DEV_INSTR;
      cnt_r <= 4'h0;
      shift_r <= 16'h0000;
      rw_r <= 1'b0;
      stream_r <= 1'b0;
      bytesLeft_r <= 2'h0;
      addr_r <= 13'h0000;
      tx_r <= 8'h00;
    end
    else if (!csActive)
    begin
      // A whole-byte stall keeps the frame except in streaming; anything else drops it
      if (cnt_r[2:0] != 3'h0 || state_r == DEV_DONE || stream_r)
      begin
        state_r <= DEV_INSTR;
        cnt_r <= 4'h0;
        stream_r <= 1'b0;
      end
    end
    else if (sclkRise)
    begin
      shift_r <= shiftNxt;
      case (state_r)
        DEV_INSTR:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (instrDone)
          begin
            rw_r <= shiftNxt[`SCP_RW_BIT];
            stream_r <= shiftNxt[`SCP_WLEN_HI:`SCP_WLEN_LO] == `SCP_WLEN_STREAM;
            bytesLeft_r <= shiftNxt[`SCP_WLEN_HI:`SCP_WLEN_LO];
            addr_r <= shiftNxt[`SCP_ADDR_W-1:0];
            tx_r <= readByte(shiftNxt[`SCP_ADDR_W-1:0]);
            cnt_r <= 4'h0;
            state_r <= DEV_DATA;
          end
        end
        DEV_DATA:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (byteDone)
          begin
            addr_r <= addr_r + 13'h0001;
            tx_r <= readByte(addr_r + 13'h0001);
            cnt_r <= 4'h0;
            // Streaming has no count, so only select can end it
            if (!stream_r)
            begin
              bytesLeft_r <= bytesLeft_r - 2'h1;
              if (bytesLeft_r == 2'h0)
              begin
                state_r <= twoWireMode_r ? DEV_INSTR : DEV_DONE;
              end
            end
          end
        end
        default:
        begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Register space: shadow copies, applied on the transfer bit; 0x00, 0x04 and 0x05 are written live at once
  always_ff @(posedge clk)
  begin
    transferPulse_r <= 1'b0;
    if (reset)
    begin
      for (int i = 0; i < `SCP_MEM_DEPTH; i++)
      begin
        shadow_r[i] <= `SCP_REG_RESET;
        live_r[i] <= `SCP_REG_RESET;
      end
    end
    else if (wrEn)
    begin
      if (addr_r[7:0] == `SCP_ADDR_CFG || addr_r[7:0] == `SCP_ADDR_UNBUF_A ||
          addr_r[7:0] == `SCP_ADDR_UNBUF_B)
      begin
        shadow_r[addr_r[7:0]] <= wrData;
        live_r[addr_r[7:0]] <= wrData;
      end
      else if (addr_r[7:0] == `SCP_ADDR_XFER)
      begin
        // Transfer bit self-clears and so reads back as zero
        if (wrData[`SCP_XFER_BIT])
        begin
          live_r <= shadow_r;
          transferPulse_r <= 1'b1;
        end
      end
      else
      begin
        shadow_r[addr_r[7:0]] <= wrData;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfgData_r <= `SCP_REG_RESET;
    end
    else
    begin
      cfgData_r <= live_r[cfgAddr];
    end
  end

  // Read data changes on falling clock (or select fall after a stall),
  // which leaves the low half after the synchroniser delays for the controller's setup
  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      link.devOe <= 1'b0;
      link.devOut <= 1'b0;
    end
    else if (!csActive)
    begin
      link.devOe <= 1'b0;
    end
    else if (sclkFall || pinFall[2])
    begin
      if (state_r == DEV_DATA && rw_r)
      begin
        link.devOut <= lsbFirst ? tx_r[cnt_r[2:0]] : tx_r[3'h7 - cnt_r[2:0]];
        link.devOe <= 1'b1;
      end
      else
      begin
        link.devOe <= 1'b0;
      end
    end
  end
endmodule

// >>> verilog/spi_cfg_if.sv
`timescale 1ns/1ns
interface spi_cfg_if;
  logic csN;
  logic sclk;
  logic ctrlOut;
  logic ctrlOe;
  logic devOut;
  logic devOe;
  // Board straps on the select wire, driven by the bench
  logic csTieLow;
  logic csTieHigh;
  logic csPin;
  logic sdio;

  assign csPin = csTieLow ? 1'b0 : (csTieHigh ? 1'b1 : csN);
  // Weak pull-down when nobody drives the data wire
  assign sdio = ctrlOe ? ctrlOut : (devOe ? devOut : 1'b0);

  modport ctrl (output csN, output sclk, output ctrlOut, output ctrlOe, input sdio);
  modport dev (input csPin, input sclk, input sdio, output devOut, output devOe);
endinterface

// >>> verilog/spi_cfg_pkg.sv
package spi_cfg_pkg;

  typedef enum logic [1:0] {DEV_INSTR, DEV_DATA, DEV_DONE} devState_t;

  typedef enum logic [2:0] {CT_IDLE, CT_SETUP, CT_BIT, CT_GAP, CT_END} ctrlState_t;

endpackage

// >>> verilog/spi_pin_sync.sv
`timescale 1ns/1ns
module spi_pin_sync
#(
  parameter logic [2:0] RESET_VAL = 3'h0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Asynchronous pins
  input wire logic [2:0] pinIn,
  // Synchronised levels and edges
  output logic [2:0] level,
  output logic [2:0] rise,
  output logic [2:0] fall
);
  logic [2:0] meta_r;
  logic [2:0] stable_r;
  logic [2:0] prev_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r <= RESET_VAL;
      stable_r <= RESET_VAL;
      prev_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= pinIn;
      stable_r <= meta_r;
      prev_r <= stable_r;
    end
  end

  assign level = stable_r;
  assign rise = stable_r & ~prev_r;
  assign fall = ~stable_r & prev_r;
endmodule
